// >>> src/dscc_regs.vh
// register map, field positions, reset values and strap pin positions
// for the deserializer strap/config control block; definitions only.
`ifndef DSCC_REGS_VH
`define DSCC_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DSCC_OFF_CFG 12'h000
`define DSCC_OFF_OVR 12'h004
`define DSCC_OFF_CTRL 12'h008
`define DSCC_OFF_STAT 12'h00C
`define DSCC_OFF_EFF 12'h010
`define DSCC_OFF_ISTAT 12'h014
`define DSCC_OFF_IMASK 12'h018

// ----------------------------------------------------------------
// cfg and eff field layout
// ----------------------------------------------------------------
`define DSCC_F_STROBE 0
`define DSCC_F_HOLD 1
`define DSCC_F_SLEEP 2
`define DSCC_F_SELFTEST 3
`define DSCC_F_MAP_LO 4
`define DSCC_F_MAP_HI 5
`define DSCC_F_SPREAD_LO 8
`define DSCC_F_SPREAD_HI 11
`define DSCC_CFG_RESET 12'h000
`define DSCC_CFG_MASK 12'hF3F

// ----------------------------------------------------------------
// ovr field layout: one select bit per option, 1 = register value
// ----------------------------------------------------------------
`define DSCC_O_STROBE 0
`define DSCC_O_HOLD 1
`define DSCC_O_SLEEP 2
`define DSCC_O_SELFTEST 3
`define DSCC_O_MAP 4
`define DSCC_O_SPREAD 5
`define DSCC_OVR_RESET 6'h00

// ----------------------------------------------------------------
// ctrl, stat and interrupt bits
// ----------------------------------------------------------------
`define DSCC_C_RELEASE 0
`define DSCC_S_LOCK 0
`define DSCC_S_PASS 1
`define DSCC_S_SELFTEST 2
`define DSCC_S_STRAPPED 3
`define DSCC_S_HELD 4
`define DSCC_I_LOCK_UP 0
`define DSCC_I_LOCK_DOWN 1
`define DSCC_I_PAYLOAD_ERR 2
`define DSCC_INT_W 3
`define DSCC_INT_RESET 3'h0

// ----------------------------------------------------------------
// strap positions on the shared data pins
// ----------------------------------------------------------------
`define DSCC_P_SLEEP 18
`define DSCC_P_STROBE 17
`define DSCC_P_SPREAD_HI 6
`define DSCC_P_SPREAD_LO 3
`define DSCC_P_MAP_HI 1
`define DSCC_P_MAP_LO 0
`define DSCC_MAP_RESET 2'h0
`define DSCC_SPREAD_RESET 4'h0

`endif

// >>> src/dscc_strap_latch.v
// strap capture for the deserializer config block.
// assumes the top keeps every shared pin released from wake-up until strapped is set.
`timescale 1ns/100ps
`include "dscc_regs.vh"

module dscc_strap_latch #(
	parameter DATA_W = 24
) (
	input wire clk,
	input wire rst,
	input wire power_down_n,
	input wire [DATA_W-1:0] data_in,
	input wire pass_in,
	output reg strapped,
	output reg strap_strobe,
	output reg strap_hold,
	output reg strap_sleep,
	output reg [1:0] strap_map,
	output reg [3:0] strap_spread
);

	reg awake_reg;

	// ----------------------------------------------------------------
	// sample once per wake-up
	// ----------------------------------------------------------------
	// one cycle of margin after wake-up so the released pins have settled
	always @(posedge clk) begin
		if (rst) begin
			awake_reg <= 1'b0;
			strapped <= 1'b0;
			strap_strobe <= 1'b0;
			strap_hold <= 1'b0;
			strap_sleep <= 1'b0;
			strap_map <= `DSCC_MAP_RESET;
			strap_spread <= `DSCC_SPREAD_RESET;
		end else if (!power_down_n) begin
			// values kept: sleep state still needs them while down
			awake_reg <= 1'b0;
			strapped <= 1'b0;
		end else begin
			awake_reg <= 1'b1;
			if (awake_reg && !strapped) begin
				strapped <= 1'b1;
				strap_strobe <= data_in[`DSCC_P_STROBE];
				strap_hold <= pass_in;
				strap_sleep <= data_in[`DSCC_P_SLEEP];
				strap_map <= data_in[`DSCC_P_MAP_HI:`DSCC_P_MAP_LO];
				strap_spread <= data_in[`DSCC_P_SPREAD_HI:`DSCC_P_SPREAD_LO];
			end
		end
	end

endmodule

// >>> src/dscc_top.v
// strap and register configuration, output state and power-down control
// for a serial-link deserializer, with an APB register slave.
// assumes lock, recovered data and payload errors come from the link on clk.
//
// Function
// - strobe select 1: outputs captured on rising clock edge; 0: falling edge.
// - hold-low set: data, control and clock outputs stay low while locked after power-up until release bit written.
// - hold-low clear: outputs toggle normally once lock goes high.
// - in power-down, output state comes from sleep select and power-down input.
// - power-down input 1 runs; 0 powers down and resets control registers.
// - self-test enable 1 runs link self-test; 0 normal operation.
// - every strap option can be replaced by a register value.
// - two-bit bit-mapping select from strap or register, default 00.
// - four-bit spread-spectrum range select from strap or register.
// - lock 1: outputs active; lock 0: outputs follow sleep select.
// - self-test pass indication 1 while error free, 0 after any error.
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
`include "dscc_regs.vh"

module dscc_top #(
	parameter DATA_W = 24,
	parameter CTRL_W = 3
) (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire power_down_n,
	input wire link_lock,
	input wire selftest_en,
	input wire payload_err,
	input wire [DATA_W-1:0] rx_data,
	input wire [CTRL_W-1:0] rx_ctrl,
	input wire [DATA_W-1:0] data_in,
	output reg [DATA_W-1:0] data_out,
	output reg [DATA_W-1:0] data_oe,
	output reg [CTRL_W-1:0] ctrl_out,
	output reg ctrl_oe,
	output reg pixel_clk_out,
	output reg pixel_clk_oe,
	input wire pass_in,
	output reg pass_out,
	output reg pass_oe,
	output reg lock_out,
	output reg selftest_active,
	output reg [1:0] map_sel,
	output reg [3:0] spread_range_sel,
	output reg irq
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	localparam OS_ACTIVE = 2'h0;
	localparam OS_LOW = 2'h1;
	localparam OS_TRI = 2'h2;
	localparam OS_HELD = 2'h3;

	reg [11:0] cfg_reg;
	reg [5:0] ovr_reg;
	reg release_reg;
	reg [`DSCC_INT_W-1:0] istat_reg;
	reg [`DSCC_INT_W-1:0] istat_next;
	reg [`DSCC_INT_W-1:0] imask_reg;
	reg lock_d_reg;
	reg pass_reg;
	reg [1:0] ostate;
	reg [31:0] rdata_next;
	reg addr_ok;

	wire strapped;
	wire strap_strobe;
	wire strap_hold;
	wire strap_sleep;
	wire [1:0] strap_map;
	wire [3:0] strap_spread;
	wire strobe_edge_sel;
	wire hold_outputs_low;
	wire sleep_state_sel;
	wire selftest_sel;
	wire [1:0] map_eff;
	wire [3:0] spread_eff;
	wire [11:0] eff_word;
	wire [`DSCC_INT_W-1:0] ev;
	wire apb_acc;
	wire apb_wr;
	wire apb_rd;
	wire launch;

	// ----------------------------------------------------------------
	// strap capture
	// ----------------------------------------------------------------
	dscc_strap_latch #(
		.DATA_W(DATA_W)
	) u_strap (
		.clk(clk),
		.rst(rst),
		.power_down_n(power_down_n),
		.data_in(data_in),
		.pass_in(pass_in),
		.strapped(strapped),
		.strap_strobe(strap_strobe),
		.strap_hold(strap_hold),
		.strap_sleep(strap_sleep),
		.strap_map(strap_map),
		.strap_spread(strap_spread)
	);

	// ----------------------------------------------------------------
	// effective option values
	// ----------------------------------------------------------------
	// straps are not checked against each other: a hold-low board keeps the rest at default
	assign strobe_edge_sel = ovr_reg[`DSCC_O_STROBE] ? cfg_reg[`DSCC_F_STROBE] : strap_strobe;
	assign hold_outputs_low = ovr_reg[`DSCC_O_HOLD] ? cfg_reg[`DSCC_F_HOLD] : strap_hold;
	assign sleep_state_sel = ovr_reg[`DSCC_O_SLEEP] ? cfg_reg[`DSCC_F_SLEEP] : strap_sleep;
	assign selftest_sel = ovr_reg[`DSCC_O_SELFTEST] ? cfg_reg[`DSCC_F_SELFTEST] : selftest_en;
	assign map_eff = ovr_reg[`DSCC_O_MAP] ? cfg_reg[`DSCC_F_MAP_HI:`DSCC_F_MAP_LO] : strap_map;
	assign spread_eff = ovr_reg[`DSCC_O_SPREAD] ? cfg_reg[`DSCC_F_SPREAD_HI:`DSCC_F_SPREAD_LO] : strap_spread;
	assign eff_word = {spread_eff, 2'b00, map_eff, selftest_sel, sleep_state_sel, hold_outputs_low, strobe_edge_sel};

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// one wait state: pready rises in the second access cycle
	assign apb_acc = psel && penable && pready;
	assign apb_wr = apb_acc && pwrite && addr_ok;
	assign apb_rd = apb_acc && !pwrite && addr_ok;

	always @* begin
		addr_ok = 1'b1;
		rdata_next = 32'h0000_0000;
		case (paddr)
			`DSCC_OFF_CFG: rdata_next[11:0] = cfg_reg;
			`DSCC_OFF_OVR: rdata_next[5:0] = ovr_reg;
			`DSCC_OFF_CTRL: rdata_next[`DSCC_C_RELEASE] = release_reg;
			`DSCC_OFF_STAT: begin
				rdata_next[`DSCC_S_LOCK] = lock_d_reg;
				rdata_next[`DSCC_S_PASS] = pass_reg;
				rdata_next[`DSCC_S_SELFTEST] = selftest_active;
				rdata_next[`DSCC_S_STRAPPED] = strapped;
				rdata_next[`DSCC_S_HELD] = hold_outputs_low && !release_reg;
			end
			`DSCC_OFF_EFF: rdata_next[11:0] = eff_word;
			`DSCC_OFF_ISTAT: rdata_next[`DSCC_INT_W-1:0] = istat_reg;
			`DSCC_OFF_IMASK: rdata_next[`DSCC_INT_W-1:0] = imask_reg;
			default: addr_ok = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addr_ok;
			if (psel && penable && !pready && !pwrite)
				prdata <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	// power-down clears them like a reset; writes while down are dropped
	always @(posedge clk) begin
		if (rst || !power_down_n) begin
			cfg_reg <= `DSCC_CFG_RESET;
			ovr_reg <= `DSCC_OVR_RESET;
			release_reg <= 1'b0;
			imask_reg <= `DSCC_INT_RESET;
		end else if (apb_wr) begin
			case (paddr)
				`DSCC_OFF_CFG: cfg_reg <= pwdata[11:0] & `DSCC_CFG_MASK;
				`DSCC_OFF_OVR: ovr_reg <= pwdata[5:0];
				`DSCC_OFF_CTRL: release_reg <= pwdata[`DSCC_C_RELEASE];
				`DSCC_OFF_IMASK: imask_reg <= pwdata[`DSCC_INT_W-1:0];
				default: release_reg <= release_reg;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// events and interrupt
	// ----------------------------------------------------------------
	assign ev[`DSCC_I_LOCK_UP] = link_lock && !lock_d_reg;
	assign ev[`DSCC_I_LOCK_DOWN] = !link_lock && lock_d_reg;
	assign ev[`DSCC_I_PAYLOAD_ERR] = selftest_active && payload_err;

	// read clears only the bits it returned: an event after the sample is kept
	always @* begin
		istat_next = istat_reg;
		if (apb_rd && paddr == `DSCC_OFF_ISTAT)
			istat_next = istat_reg & ~prdata[`DSCC_INT_W-1:0];
		istat_next = istat_next | ev;
	end

	always @(posedge clk) begin
		if (rst || !power_down_n) begin
			istat_reg <= `DSCC_INT_RESET;
			lock_d_reg <= 1'b0;
			irq <= 1'b0;
		end else begin
			istat_reg <= istat_next;
			lock_d_reg <= link_lock;
			irq <= |(istat_next & imask_reg);
		end
	end

	// ----------------------------------------------------------------
	// self-test
	// ----------------------------------------------------------------
	// pass restarts high at each self-test entry and latches low on error
	always @(posedge clk) begin
		if (rst || !power_down_n) begin
			selftest_active <= 1'b0;
			pass_reg <= 1'b1;
		end else begin
			selftest_active <= selftest_sel && strapped;
			if (selftest_sel && !selftest_active)
				pass_reg <= 1'b1;
			else if (selftest_active && payload_err)
				pass_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// output state selection
	// ----------------------------------------------------------------
	// after wake-up pins stay released until straps are in, since they double as strap inputs
	always @* begin
		if (!power_down_n)
			ostate = sleep_state_sel ? OS_LOW : OS_TRI;
		else if (!strapped)
			ostate = OS_TRI;
		else if (!link_lock)
			ostate = sleep_state_sel ? OS_TRI : OS_LOW;
		else if (hold_outputs_low && !release_reg)
			ostate = OS_HELD;
		else
			ostate = OS_ACTIVE;
	end

	// clock toggles every cycle; data moves on the edge opposite the capture edge
	assign launch = (pixel_clk_out == strobe_edge_sel);

	always @(posedge clk) begin
		if (rst) begin
			data_out <= {DATA_W{1'b0}};
			data_oe <= {DATA_W{1'b0}};
			ctrl_out <= {CTRL_W{1'b0}};
			ctrl_oe <= 1'b0;
			pixel_clk_out <= 1'b0;
			pixel_clk_oe <= 1'b0;
		end else begin
			case (ostate)
				OS_ACTIVE: begin
					data_oe <= {DATA_W{1'b1}};
					ctrl_oe <= 1'b1;
					pixel_clk_oe <= 1'b1;
					pixel_clk_out <= !pixel_clk_out;
					if (launch) begin
						data_out <= rx_data;
						ctrl_out <= rx_ctrl;
					end
				end
				OS_LOW, OS_HELD: begin
					data_out <= {DATA_W{1'b0}};
					data_oe <= {DATA_W{1'b1}};
					ctrl_out <= {CTRL_W{1'b0}};
					ctrl_oe <= 1'b1;
					pixel_clk_out <= 1'b0;
					pixel_clk_oe <= 1'b1;
				end
				default: begin
					data_out <= {DATA_W{1'b0}};
					data_oe <= {DATA_W{1'b0}};
					ctrl_out <= {CTRL_W{1'b0}};
					ctrl_oe <= 1'b0;
					pixel_clk_out <= 1'b0;
					pixel_clk_oe <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status outputs and pass pin
	// ----------------------------------------------------------------
	// pass pin doubles as the hold-low strap, so it is released until strapped
	always @(posedge clk) begin
		if (rst) begin
			lock_out <= 1'b0;
			pass_out <= 1'b0;
			pass_oe <= 1'b0;
			map_sel <= `DSCC_MAP_RESET;
			spread_range_sel <= `DSCC_SPREAD_RESET;
		end else begin
			lock_out <= link_lock && power_down_n;
			pass_oe <= power_down_n && strapped;
			pass_out <= pass_reg && power_down_n;
			map_sel <= map_eff;
			spread_range_sel <= spread_eff;
		end
	end

endmodule

// >>> tb/dscc_board.sv
// board strap resistors and the pass pin wire
// assumes the bench sets straps before power-up
`timescale 1ns/100ps
module dscc_board (
	input wire hold,
	input wire sleep,
	input wire strobe,
	input wire [1:0] map,
	input wire [3:0] spread,
	input wire pass_out,
	input wire pass_oe,
	output wire [23:0] data_in,
	output wire pass_in
);
	// hold-low strap leaves every other strap at its pull-down
	wire k = !hold;
	// data straps shown regardless of enables, as the block samples them
	assign data_in = {5'h00, sleep & k, strobe & k, 10'h000, spread & {4{k}}, 1'h0, map & {2{k}}};
	assign pass_in = pass_oe ? pass_out : hold;
endmodule

// >>> tb/dscc_checker.sv
// port assertions for the strap and config block
// assumes it is bound into every dscc_top
`timescale 1ns/100ps
module dscc_checker #(
	parameter DATA_W = 24
) (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire power_down_n,
	input wire link_lock,
	input wire payload_err,
	input wire [DATA_W-1:0] data_out,
	input wire [DATA_W-1:0] data_oe,
	input wire pixel_clk_out,
	input wire pixel_clk_oe,
	input wire lock_out,
	input wire selftest_active,
	input wire pass_out,
	input wire irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ----
	// sequences
	// ----
	sequence s_setup;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence s_down;
		!power_down_n [*2];
	endsequence
	a_setup_answer: assert property (s_setup |=> pready) else $error("no ready after access");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_down_clear: assert property (s_down |=> !irq && !lock_out && !selftest_active)
		else $error("power-down left state set");
	a_sleep_quiet: assert property (s_down |-> (data_out & data_oe) == 0 && !(pixel_clk_out && pixel_clk_oe))
		else $error("pins active in power-down");
	a_unlock_quiet: assert property (!link_lock [*3] |-> (data_out & data_oe) == 0)
		else $error("pins active while unlocked");
	a_lock_follow: assert property (!$past(rst) |-> lock_out == $past(link_lock && power_down_n))
		else $error("lock output wrong");
	a_pass_drop: assert property (selftest_active && payload_err && power_down_n ##1 power_down_n |=> !pass_out)
		else $error("pass stayed high after error");
endmodule
bind dscc_top dscc_checker #(.DATA_W(DATA_W)) u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .power_down_n(power_down_n), .link_lock(link_lock),
	.payload_err(payload_err), .data_out(data_out), .data_oe(data_oe), .pixel_clk_out(pixel_clk_out),
	.pixel_clk_oe(pixel_clk_oe), .lock_out(lock_out), .selftest_active(selftest_active),
	.pass_out(pass_out), .irq(irq));

// >>> tb/tb_top.sv
// self-checking bench for the strap and config block over apb
// assumes the board model supplies the strap levels
`timescale 1ns/100ps
`include "dscc_regs.vh"
module tb_top;
	reg clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0, rd;
	reg power_down_n = 1'h0, link_lock = 1'h0, selftest_en = 1'h0, payload_err = 1'h0;
	reg [23:0] rx_data = 24'h0, last;
	reg [2:0] rx_ctrl = 3'h0;
	reg s_hold = 1'h0, s_sleep = 1'h0, s_strobe = 1'h0;
	reg [1:0] s_map = 2'h0;
	reg [3:0] s_spread = 4'h0;
	reg [32:0] exp_q[$];
	wire [31:0] prdata;
	wire pready, pslverr, ctrl_oe, pixel_clk_out, pixel_clk_oe, pass_in, pass_out, pass_oe, lock_out;
	wire selftest_active, irq;
	wire [23:0] data_in, data_out, data_oe;
	wire [2:0] ctrl_out;
	wire [1:0] map_sel;
	wire [3:0] spread_range_sel;
	integer err_total = 0, checks_done = 0, seed = 66761, cycles = 0, i, k;
	dscc_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_down_n(power_down_n),
		.link_lock(link_lock), .selftest_en(selftest_en), .payload_err(payload_err), .rx_data(rx_data),
		.rx_ctrl(rx_ctrl), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ctrl_out(ctrl_out),
		.ctrl_oe(ctrl_oe), .pixel_clk_out(pixel_clk_out), .pixel_clk_oe(pixel_clk_oe), .pass_in(pass_in),
		.pass_out(pass_out), .pass_oe(pass_oe), .lock_out(lock_out), .selftest_active(selftest_active),
		.map_sel(map_sel), .spread_range_sel(spread_range_sel), .irq(irq));
	dscc_board board (.hold(s_hold), .sleep(s_sleep), .strobe(s_strobe), .map(s_map), .spread(s_spread),
		.pass_out(pass_out), .pass_oe(pass_oe), .data_in(data_in), .pass_in(pass_in));
	initial begin
		forever #20 clk = ~clk;
	end
	// ----
	// shared tasks
	// ----
	task chk(input [32:0] seen, input [32:0] want);
		begin
			checks_done = checks_done + 1;
			if (seen !== want) begin
				err_total = err_total + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
			end
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", checks_done, err_total);
			if (err_total == 0 && checks_done > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// one apb transfer; reads leave their expected {pslverr, prdata} for the monitor
	task apb(input w, input [11:0] a, input [31:0] d, input [32:0] e);
		begin
			@(posedge clk);
			if (!w)
				exp_q.push_back(e);
			{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
			@(posedge clk);
			penable <= 1'h1;
			do @(posedge clk); while (pready !== 1'h1);
			{psel, penable} <= 2'h0;
		end
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (psel && penable && pready && !pwrite)
			chk({pslverr, prdata}, exp_q.pop_front());
		if (cycles == 4000) begin
			err_total = err_total + 1;
			print_verdict;
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		tick(10);
		rst <= 1'h0;
		link_lock <= 1'h1;
		for (i = 0; i < 4; i = i + 1) begin
			s_strobe <= i[0];
			s_sleep <= i[1];
			s_map <= $random(seed);
			s_spread <= $random(seed);
			tick(1);
			power_down_n <= 1'h1;
			tick(5);
			apb(1'h0, `DSCC_OFF_EFF, 32'h0, {21'h0, s_spread, 2'h0, s_map, 1'h0, s_sleep, 1'h0, s_strobe});
			chk(map_sel, s_map);
			chk(spread_range_sel, s_spread);
			for (k = 0; k < 8; k = k + 1) begin
				last = data_out;
				rx_data <= $random(seed);
				rx_ctrl <= $random(seed);
				tick(1);
				if (data_out !== last)
					chk(pixel_clk_out, !s_strobe);
			end
			tick(3);
			chk(data_out, rx_data);
			chk(data_oe, 24'hFFFFFF);
			chk(ctrl_out, rx_ctrl);
			chk({ctrl_oe, pixel_clk_oe}, 2'h3);
			link_lock <= 1'h0;
			tick(4);
			chk(data_oe, s_sleep ? 24'h0 : 24'hFFFFFF);
			power_down_n <= 1'h0;
			tick(3);
			chk(data_oe, s_sleep ? 24'hFFFFFF : 24'h0);
			link_lock <= 1'h1;
		end
		$display("test strap sweep done");
		power_down_n <= 1'h1;
		rd = $random(seed) & 32'hF3F;
		apb(1'h1, `DSCC_OFF_CFG, rd, 33'h0);
		apb(1'h1, `DSCC_OFF_OVR, 32'h3F, 33'h0);
		apb(1'h0, `DSCC_OFF_CFG, 32'h0, {1'h0, rd});
		apb(1'h0, `DSCC_OFF_EFF, 32'h0, {1'h0, rd});
		chk(map_sel, rd[5:4]);
		chk(spread_range_sel, rd[11:8]);
		apb(1'h1, 12'h01C, 32'hFFFFFFFF, 33'h0);
		apb(1'h0, 12'h01C, 32'h0, 33'h100000000);
		power_down_n <= 1'h0;
		s_hold <= 1'h1;
		tick(2);
		power_down_n <= 1'h1;
		apb(1'h0, `DSCC_OFF_CFG, 32'h0, 33'h0);
		apb(1'h0, `DSCC_OFF_OVR, 32'h0, 33'h0);
		apb(1'h0, `DSCC_OFF_STAT, 32'h0, 33'h01B);
		$display("test override done");
		chk(data_oe, 24'hFFFFFF);
		chk(data_out, 24'h0);
		apb(1'h1, `DSCC_OFF_CTRL, 32'h1, 33'h0);
		tick(6);
		chk(data_out, rx_data);
		selftest_en <= 1'h1;
		apb(1'h1, `DSCC_OFF_IMASK, 32'h4, 33'h0);
		apb(1'h0, `DSCC_OFF_ISTAT, 32'h0, 33'h1);
		chk(selftest_active, 1'h1);
		chk(pass_out, 1'h1);
		chk(pass_oe, 1'h1);
		for (k = 0; k < 2; k = k + 1) begin
			payload_err <= 1'h1;
			tick(1);
			payload_err <= 1'h0;
			tick(3);
			chk(pass_out, 1'h0);
			chk(irq, k == 0);
			apb(1'h0, `DSCC_OFF_ISTAT, 32'h0, 33'h4);
			tick(2);
			chk(irq, 1'h0);
			apb(1'h1, `DSCC_OFF_IMASK, 32'h0, 33'h0);
		end
		selftest_en <= 1'h0;
		tick(3);
		chk(selftest_active, 1'h0);
		$display("test hold and self-test done");
		print_verdict;
	end
endmodule
